// ==== logic/cfq_rom.v ====
// Extended query table read-only store answering query reads over the 16-bit bus.
`timescale 1ns/1ps
`default_nettype none

`include "cfq_rom_map.vh"

module cfq_rom #(
    parameter [7:0] PART_REGIONS = 8'h01,
    parameter [15:0] REGION_DESC_SIZE = 16'h0024,
    parameter [15:0] IDENT_PARTS = 16'h0001,
    parameter [7:0] OPS_IN_PART = 8'h11,
    parameter [7:0] OPS_DUR_PROG = 8'h00,
    parameter [7:0] OPS_DUR_ERASE = 8'h00,
    parameter [7:0] ERASE_REGIONS = 8'h02
) (
    // Clock and reset.
    input wire sys_clk,
    input wire nrst,
    // Stacking straps.
    input wire stacked,
    input wire die_second,
    // Query read port.
    input wire query_mode,
    input wire rd_en,
    input wire [`CFQ_ADDR_W-1:0] rd_addr,
    output reg [15:0] rd_data_q,
    output reg rd_valid_q
);

    ////////////////////////////////////////////////////////////////////////////

    // Byte 112 is the only entry that follows the stacking straps.
    reg [7:0] feat3_byte;
    // One byte lane per entry; a lane is zero unless its own address is read.
    wire [8*`CFQ_CELLS-1:0] cell_bytes;
    reg [7:0] byte_d;
    integer i;

    always @* begin
        if (!stacked) begin
            feat3_byte = `CFQ_FEAT3_SINGLE;
        end else if (die_second) begin
            feat3_byte = `CFQ_FEAT3_DIE2;
        end else begin
            feat3_byte = `CFQ_FEAT3_DIE1;
        end
    end

    // Every entry is a fixed lane, so top- and bottom-boot builds answer
    // identically and no entry can shadow another.
    cfq_rom_cell #(.ADDR(`CFQ_PTR_LO_ADDR)) u_ptr_lo (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_PTR_LO),
        .cell_byte(cell_bytes[8*0 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_PTR_HI_ADDR)) u_ptr_hi (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_PTR_HI),
        .cell_byte(cell_bytes[8*1 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_SIG_P)) u_sig_p (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_SIG_P),
        .cell_byte(cell_bytes[8*2 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_SIG_R)) u_sig_r (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_SIG_R),
        .cell_byte(cell_bytes[8*3 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_SIG_I)) u_sig_i (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_SIG_I),
        .cell_byte(cell_bytes[8*4 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_VER_MAJOR)) u_ver_major (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_VER_MAJOR),
        .cell_byte(cell_bytes[8*5 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_VER_MINOR)) u_ver_minor (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_VER_MINOR),
        .cell_byte(cell_bytes[8*6 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_FEAT0)) u_feat0 (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_FEAT0),
        .cell_byte(cell_bytes[8*7 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_FEAT1)) u_feat1 (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_FEAT1),
        .cell_byte(cell_bytes[8*8 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_FEAT2)) u_feat2 (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_FEAT2),
        .cell_byte(cell_bytes[8*9 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_FEAT3)) u_feat3 (
        .rd_addr(rd_addr),
        .cell_value(feat3_byte),
        .cell_byte(cell_bytes[8*10 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_AFTER_SUSP)) u_after_susp (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_AFTER_SUSP),
        .cell_byte(cell_bytes[8*11 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_BSM_LO)) u_bsm_lo (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_BSM_LO),
        .cell_byte(cell_bytes[8*12 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_BSM_HI)) u_bsm_hi (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_BSM_HI),
        .cell_byte(cell_bytes[8*13 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_VCC_OPT)) u_vcc_opt (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_VCC_OPT),
        .cell_byte(cell_bytes[8*14 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_VPP_OPT)) u_vpp_opt (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_VPP_OPT),
        .cell_byte(cell_bytes[8*15 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP_COUNT)) u_otp_count (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_OTP_COUNT),
        .cell_byte(cell_bytes[8*16 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP1_LOCK_LO)) u_otp1_lock_lo (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_OTP1_LOCK_LO),
        .cell_byte(cell_bytes[8*17 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP1_LOCK_HI)) u_otp1_lock_hi (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_OTP1_LOCK_HI),
        .cell_byte(cell_bytes[8*18 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP1_FACT)) u_otp1_fact (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_OTP1_FACT),
        .cell_byte(cell_bytes[8*19 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP1_USER)) u_otp1_user (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_OTP1_USER),
        .cell_byte(cell_bytes[8*20 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP2_LOCK_B0)) u_otp2_lock_b0 (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_OTP2_LOCK),
        .cell_byte(cell_bytes[8*21 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP2_LOCK_B1)) u_otp2_lock_b1 (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_ZERO),
        .cell_byte(cell_bytes[8*22 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP2_LOCK_B2)) u_otp2_lock_b2 (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_ZERO),
        .cell_byte(cell_bytes[8*23 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP2_LOCK_B3)) u_otp2_lock_b3 (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_ZERO),
        .cell_byte(cell_bytes[8*24 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP2_FACT_GRP_LO)) u_otp2_fact_grp_lo (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_ZERO),
        .cell_byte(cell_bytes[8*25 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP2_FACT_GRP_HI)) u_otp2_fact_grp_hi (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_ZERO),
        .cell_byte(cell_bytes[8*26 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP2_FACT_SIZE)) u_otp2_fact_size (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_ZERO),
        .cell_byte(cell_bytes[8*27 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP2_USER_GRP_LO)) u_otp2_user_grp_lo (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_OTP2_USER_GRP),
        .cell_byte(cell_bytes[8*28 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP2_USER_GRP_HI)) u_otp2_user_grp_hi (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_ZERO),
        .cell_byte(cell_bytes[8*29 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OTP2_USER_SIZE)) u_otp2_user_size (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_OTP2_USER_SIZE),
        .cell_byte(cell_bytes[8*30 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_PAGE_SIZE)) u_page_size (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_PAGE_SIZE),
        .cell_byte(cell_bytes[8*31 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_BURST_COUNT)) u_burst_count (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_BURST_COUNT),
        .cell_byte(cell_bytes[8*32 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_BURST_1)) u_burst_1 (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_BURST_1),
        .cell_byte(cell_bytes[8*33 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_BURST_2)) u_burst_2 (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_BURST_2),
        .cell_byte(cell_bytes[8*34 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_BURST_3)) u_burst_3 (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_BURST_3),
        .cell_byte(cell_bytes[8*35 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_BURST_4)) u_burst_4 (
        .rd_addr(rd_addr),
        .cell_value(`CFQ_BURST_4),
        .cell_byte(cell_bytes[8*36 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_PART_REGIONS)) u_part_regions (
        .rd_addr(rd_addr),
        .cell_value(PART_REGIONS),
        .cell_byte(cell_bytes[8*37 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_REGION_SIZE_LO)) u_region_size_lo (
        .rd_addr(rd_addr),
        .cell_value(REGION_DESC_SIZE[7:0]),
        .cell_byte(cell_bytes[8*38 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_REGION_SIZE_HI)) u_region_size_hi (
        .rd_addr(rd_addr),
        .cell_value(REGION_DESC_SIZE[15:8]),
        .cell_byte(cell_bytes[8*39 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_IDENT_PARTS_LO)) u_ident_parts_lo (
        .rd_addr(rd_addr),
        .cell_value(IDENT_PARTS[7:0]),
        .cell_byte(cell_bytes[8*40 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_IDENT_PARTS_HI)) u_ident_parts_hi (
        .rd_addr(rd_addr),
        .cell_value(IDENT_PARTS[15:8]),
        .cell_byte(cell_bytes[8*41 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OPS_IN_PART)) u_ops_in_part (
        .rd_addr(rd_addr),
        .cell_value(OPS_IN_PART),
        .cell_byte(cell_bytes[8*42 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OPS_DUR_PROG)) u_ops_dur_prog (
        .rd_addr(rd_addr),
        .cell_value(OPS_DUR_PROG),
        .cell_byte(cell_bytes[8*43 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_OPS_DUR_ERASE)) u_ops_dur_erase (
        .rd_addr(rd_addr),
        .cell_value(OPS_DUR_ERASE),
        .cell_byte(cell_bytes[8*44 +: 8])
    );

    cfq_rom_cell #(.ADDR(`CFQ_A_ERASE_REGIONS)) u_erase_regions (
        .rd_addr(rd_addr),
        .cell_value(ERASE_REGIONS),
        .cell_byte(cell_bytes[8*45 +: 8])
    );

    // Exactly one lane is live for a listed address, so an OR of all lanes
    // yields the read byte, and an unlisted address reads zero.
    always @* begin
        byte_d = `CFQ_ZERO;
        for (i = 0; i < `CFQ_CELLS; i = i + 1) begin
            byte_d = byte_d | cell_bytes[8*i +: 8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // One registered stage for every query read, the same as an array read.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_q <= 16'h0000;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_en & query_mode;
            if (rd_en & query_mode) begin
                rd_data_q <= {8'h00, byte_d};
            end
        end
    end

endmodule

////////////////////////////////////////////////////////////////////////////////

// One table entry: it shows its byte only while its own address is read.
module cfq_rom_cell #(
    parameter [`CFQ_ADDR_W-1:0] ADDR = `CFQ_FIRST
) (
    // Address of the read in flight.
    input wire [`CFQ_ADDR_W-1:0] rd_addr,
    // Contents of this entry.
    input wire [7:0] cell_value,
    // Entry byte, or zero for any other address.
    output wire [7:0] cell_byte
);

    assign cell_byte = (rd_addr == ADDR) ? cell_value : `CFQ_ZERO;

endmodule
`default_nettype wire

// ==== logic/cfq_rom_map.vh ====
// Word addresses, byte contents and sizes of the extended query table.
`ifndef CFQ_ROM_MAP_VH
`define CFQ_ROM_MAP_VH

`define CFQ_ADDR_W 9
`define CFQ_FIRST 9'h10A
`define CFQ_LAST 9'h135
`define CFQ_CELLS 46
`define CFQ_A_SIG_P 9'h10A
`define CFQ_A_SIG_R 9'h10B
`define CFQ_A_SIG_I 9'h10C
`define CFQ_A_VER_MAJOR 9'h10D
`define CFQ_A_VER_MINOR 9'h10E
`define CFQ_A_FEAT0 9'h10F
`define CFQ_A_FEAT1 9'h110
`define CFQ_A_FEAT2 9'h111
`define CFQ_A_FEAT3 9'h112
`define CFQ_A_AFTER_SUSP 9'h113
`define CFQ_A_BSM_LO 9'h114
`define CFQ_A_BSM_HI 9'h115
`define CFQ_A_VCC_OPT 9'h116
`define CFQ_A_VPP_OPT 9'h117
`define CFQ_A_OTP_COUNT 9'h118
`define CFQ_A_OTP1_LOCK_LO 9'h119
`define CFQ_A_OTP1_LOCK_HI 9'h11A
`define CFQ_A_OTP1_FACT 9'h11B
`define CFQ_A_OTP1_USER 9'h11C
`define CFQ_A_OTP2_LOCK_B0 9'h11D
`define CFQ_A_OTP2_LOCK_B1 9'h11E
`define CFQ_A_OTP2_LOCK_B2 9'h11F
`define CFQ_A_OTP2_LOCK_B3 9'h120
`define CFQ_A_OTP2_FACT_GRP_LO 9'h121
`define CFQ_A_OTP2_FACT_GRP_HI 9'h122
`define CFQ_A_OTP2_FACT_SIZE 9'h123
`define CFQ_A_OTP2_USER_GRP_LO 9'h124
`define CFQ_A_OTP2_USER_GRP_HI 9'h125
`define CFQ_A_OTP2_USER_SIZE 9'h126
`define CFQ_A_PAGE_SIZE 9'h127
`define CFQ_A_BURST_COUNT 9'h128
`define CFQ_A_BURST_1 9'h129
`define CFQ_A_BURST_2 9'h12A
`define CFQ_A_BURST_3 9'h12B
`define CFQ_A_BURST_4 9'h12C
`define CFQ_A_PART_REGIONS 9'h12D
`define CFQ_A_REGION_SIZE_LO 9'h12E
`define CFQ_A_REGION_SIZE_HI 9'h12F
`define CFQ_A_IDENT_PARTS_LO 9'h130
`define CFQ_A_IDENT_PARTS_HI 9'h131
`define CFQ_A_OPS_IN_PART 9'h132
`define CFQ_A_OPS_DUR_PROG 9'h133
`define CFQ_A_OPS_DUR_ERASE 9'h134
`define CFQ_A_ERASE_REGIONS 9'h135
`define CFQ_PTR_LO_ADDR 9'h015
`define CFQ_PTR_HI_ADDR 9'h016
`define CFQ_PTR_LO 8'h0A
`define CFQ_PTR_HI 8'h01
`define CFQ_SIG_P 8'h50
`define CFQ_SIG_R 8'h52
`define CFQ_SIG_I 8'h49
`define CFQ_VER_MAJOR 8'h31
`define CFQ_VER_MINOR 8'h34
`define CFQ_FEAT0 8'hE6
`define CFQ_FEAT1 8'h01
`define CFQ_FEAT2 8'h00
`define CFQ_FEAT3_SINGLE 8'h00
`define CFQ_FEAT3_DIE1 8'h40
`define CFQ_FEAT3_DIE2 8'h00
`define CFQ_AFTER_SUSP 8'h01
`define CFQ_BSM_LO 8'h03
`define CFQ_BSM_HI 8'h00
`define CFQ_VCC_OPT 8'h18
`define CFQ_VPP_OPT 8'h90
`define CFQ_OTP_COUNT 8'h02
`define CFQ_OTP1_LOCK_LO 8'h80
`define CFQ_OTP1_LOCK_HI 8'h00
`define CFQ_OTP1_FACT 8'h03
`define CFQ_OTP1_USER 8'h03
`define CFQ_OTP2_LOCK 8'h89
`define CFQ_OTP2_USER_GRP 8'h10
`define CFQ_OTP2_USER_SIZE 8'h04
`define CFQ_PAGE_SIZE 8'h05
`define CFQ_BURST_COUNT 8'h04
`define CFQ_BURST_1 8'h01
`define CFQ_BURST_2 8'h02
`define CFQ_BURST_3 8'h03
`define CFQ_BURST_4 8'h07
`define CFQ_ZERO 8'h00

`endif

// ==== sim/cfq_host.sv ====
// Host controller model that issues query reads.
`timescale 1ns/1ps
`default_nettype none
module cfq_host (
    input wire logic sys_clk,
    output logic query_mode,
    output logic rd_en,
    output logic [8:0] rd_addr
);
    initial {query_mode, rd_en, rd_addr} = '0;
    // Back-to-back calls keep rd_en high, one read per cycle.
    task automatic rd(input logic q, input logic [8:0] a);
        @(posedge sys_clk);
        query_mode <= q;
        rd_en <= 1'b1;
        rd_addr <= a;
    endtask
    // An idle address means nothing, so it is not left at the last value.
    task automatic idle();
        @(posedge sys_clk);
        rd_en <= 1'b0;
        rd_addr <= ~rd_addr;
    endtask
endmodule
`default_nettype wire

// ==== sim/cfq_rom_chk.sv ====
// Checker of query read timing and table contents.
`timescale 1ns/1ps
`default_nettype none
module cfq_rom_chk (
    input wire sys_clk, nrst, stacked, die_second, query_mode, rd_en, rd_valid_q,
    input wire [8:0] rd_addr,
    input wire [15:0] rd_data_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire tk = rd_en & query_mode;
    property p_take; tk |=> rd_valid_q; endproperty
    a_take: assert property (p_take) else $error("no answer");
    property p_ref; !tk |=> !rd_valid_q; endproperty
    a_ref: assert property (p_ref) else $error("stray answer");
    property p_hold; !rd_valid_q |-> $stable(rd_data_q); endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_hi; rd_valid_q |-> rd_data_q[15:8] == 8'h00; endproperty
    a_hi: assert property (p_hi) else $error("upper byte");
    property p_sig; tk && rd_addr == 9'h10A |=> rd_data_q == 16'h0050; endproperty
    a_sig: assert property (p_sig) else $error("signature");
    property p_ver; tk && rd_addr == 9'h10E |=> rd_data_q == 16'h0034; endproperty
    a_ver: assert property (p_ver) else $error("version");
    property p_die; tk && rd_addr == 9'h112 |=> rd_data_q[6] == (stacked & !die_second); endproperty
    a_die: assert property (p_die) else $error("die byte");
    property p_ptr; tk && rd_addr == 9'h015 |=> rd_data_q == 16'h000A; endproperty
    a_ptr: assert property (p_ptr) else $error("pointer");
    property p_burst; tk && rd_addr >= 9'h129 && rd_addr <= 9'h12C
        |=> rd_data_q[7:3] == 5'h00; endproperty
    a_burst: assert property (p_burst) else $error("burst code too wide");
endmodule
bind cfq_rom cfq_rom_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .stacked(stacked),
    .die_second(die_second), .query_mode(query_mode), .rd_en(rd_en), .rd_valid_q(rd_valid_q),
    .rd_addr(rd_addr), .rd_data_q(rd_data_q));
`default_nettype wire

// ==== sim/test_cfq_rom.sv ====
// Self-checking bench for the query table store.
`timescale 1ns/1ps
`default_nettype none
module test_cfq_rom;
    logic sys_clk = 1'b0, nrst = 1'b0, stacked = 1'b0, die_second = 1'b0;
    wire logic query_mode, rd_en, rd_valid_q;
    wire logic [8:0] rd_addr;
    wire logic [15:0] rd_data_q;
    int num_errors = 0, n_checks = 0, seed = 32'hF6430809;
    logic [15:0] expq[$];
    localparam logic [351:0] TBL = 352'h5052493134E60100000103001890028000030389000000000000100004050401020307012400010011000002;
    cfq_rom dut (.sys_clk(sys_clk), .nrst(nrst), .stacked(stacked), .die_second(die_second),
        .query_mode(query_mode), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
        .rd_valid_q(rd_valid_q));
    cfq_host host (.sys_clk(sys_clk), .query_mode(query_mode), .rd_en(rd_en), .rd_addr(rd_addr));
    initial forever #2.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] model(input logic [8:0] a);
        if (a == 9'h112) return {9'h000, stacked & !die_second, 6'h00};
        if (a >= 9'h10A && a <= 9'h135) return {8'h00, TBL[(12'h135 - a) * 8 +: 8]};
        return (a == 9'h015) ? 16'h000A : (a == 9'h016) ? 16'h0001 : 16'h0000;
    endfunction
    task automatic rd(input logic q, input logic [8:0] a);
        host.rd(q, a);
        if (q) expq.push_back(model(a));
    endtask
    always @(negedge sys_clk) if (rd_valid_q === 1'b1)
        chk(rd_data_q, expq.size() ? expq.pop_front() : 16'hXXXX);
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            {stacked, die_second} <= {s != 0, s == 2};
            rd(1'b1, 9'h015);
            rd(1'b1, 9'h016);
            for (int a = 9'h10A; a <= 9'h135; a++) rd(1'b1, a[8:0]);
            host.idle();
            $display("scan %0d done", s);
        end
        // Reset in mid-run, once the answer of the last read has been checked.
        @(posedge sys_clk);
        nrst <= 1'b0;
        @(negedge sys_clk);
        chk(rd_data_q, 16'h0000);
        chk({15'h0000, rd_valid_q}, 16'h0000);
        @(posedge sys_clk);
        nrst <= 1'b1;
        $display("reset done");
        for (int i = 0; i < 200; i++) rd(i[0], 9'($random(seed)));
        host.idle();
        for (int i = 0; i < 10 && expq.size() > 0; i++) @(posedge sys_clk);
        if (expq.size() > 0) num_errors++;
        $display("random done");
        report_and_stop();
    end
endmodule
`default_nettype wire
